/* rtl/owc_dev.sv */
// Device end: decodes commands, stores written bytes, returns read bytes.
//
// How it works
// - Command then eight data bits, in or out.
// - Every byte travels least significant bit first.
// - Host rate limited; device accepts any slower.
// - Long low is a break; engine drops the transfer and waits for release.
// - Ready for command soon after break release.
// - Host breaks first, and after reply timeout.
// - Sender opens each bit with start low.
// - Sender holds bit value until zero-low time.
// - Sender releases high until bit cycle ends.
// - No timeout between bits received by the device, ever.
// - Reply starts one response delay after command.
// - Command bit seven high writes, low reads.
// - Command bits six to zero address register.
// - Command is exactly eight valid bits.
// - Line is open drain, low only.
// - Host should break before each transaction group.
`timescale 1ns/1ps
module owc_dev #(
    parameter owc_pkg::owc_cnt_t BRK_CYC = owc_pkg::BRK_CYC_DEF,
    parameter owc_pkg::owc_cnt_t RSP_CYC = owc_pkg::RSP_CYC_DEF,
    parameter owc_pkg::owc_cnt_t D_CYC   = owc_pkg::D_CYC_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    owc_link_if.dev                         link,
    output      logic [owc_pkg::ADDR_W-1:0] reg_addr,
    output      logic [owc_pkg::BYTE_W-1:0] reg_wdata,
    output      logic                       reg_wr,
    output      logic                       reg_rd,
    input  wire logic [owc_pkg::BYTE_W-1:0] reg_rdata,
    output      logic                       break_seen,
    output      logic                       busy
);
    import owc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        D_CMD   = 3'h0,
        D_WDATA = 3'h4,
        D_RSPW  = 3'h1,
        D_TX    = 3'h3,
        D_RECOV = 3'h2
    } owc_dst_t;

    owc_dst_t          state_q;
    owc_cnt_t          tim_q;
    owc_cnt_t          low_q;
    logic              line;
    logic              line_q;
    logic              rise;
    logic              brk;
    logic              rxb;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] sh_q;
    logic [2:0]        bit_q;
    logic [ADDR_W-1:0] addr_q;
    logic [BYTE_W-1:0] wdata_q;
    logic              wr_q;
    logic              rd_q;
    logic              brk_q;
    logic              drv_n_q;

    assign line          = link.single_wire_line;
    assign rise          = line && !line_q;
    assign link.dev_out  = 1'b0;
    assign link.dev_oe_n = drv_n_q;
    assign reg_addr      = addr_q;
    assign reg_wdata     = wdata_q;
    assign reg_wr        = wr_q;
    assign reg_rd        = rd_q;
    assign break_seen    = brk_q;
    assign busy          = (state_q != D_CMD);

    // ------------------------------------------------------------
    // Line sampling and break detection
    // ------------------------------------------------------------
    // The low counter saturates at the break length so that one
    // long low gives exactly one break, however long it lasts.
    always_ff @(posedge clk) begin
        if (rst) begin
            line_q <= 1'b1;
            low_q  <= '0;
        end else if (ce) begin
            line_q <= line;
            if (line) begin
                low_q <= '0;
            end else if (low_q != BRK_CYC) begin
                low_q <= owc_cnt_t'(low_q + 1'b1);
            end
        end
    end

    // The counter still holds the low length in the cycle of the rise.
    assign brk     = !line && (low_q == BRK_CYC - 1'b1);
    assign rxb     = owc_rx_bit(low_q, H_THR_CYC);
    assign rx_byte = {rxb, sh_q[BYTE_W-1:1]};

    // ------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= D_CMD;
            tim_q   <= '0;
            sh_q    <= '0;
            bit_q   <= '0;
            addr_q  <= '0;
            wdata_q <= '0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            brk_q   <= 1'b0;
        end else if (ce) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            brk_q <= 1'b0;
            if (brk) begin
                // A break wins over any transfer, including our own reply.
                state_q <= D_RECOV;
                tim_q   <= '0;
                bit_q   <= '0;
                brk_q   <= 1'b1;
            end else begin
                unique case (state_q)
                    D_RECOV: begin
                        if (line) begin
                            state_q <= D_CMD;
                        end
                    end
                    D_CMD: begin
                        // Idle high time is unbounded between bits.
                        if (rise) begin
                            sh_q  <= rx_byte;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'h7) begin
                                addr_q <= rx_byte[ADDR_W-1:0];
                                if (rx_byte[CMD_DIR_BIT]) begin
                                    state_q <= D_WDATA;
                                end else begin
                                    rd_q    <= 1'b1;
                                    tim_q   <= '0;
                                    state_q <= D_RSPW;
                                end
                            end
                        end
                    end
                    D_WDATA: begin
                        if (rise) begin
                            sh_q  <= rx_byte;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'h7) begin
                                wdata_q <= rx_byte;
                                wr_q    <= 1'b1;
                                state_q <= D_CMD;
                            end
                        end
                    end
                    D_RSPW: begin
                        // The user side has the whole delay to present data.
                        tim_q <= owc_cnt_t'(tim_q + 1'b1);
                        if (tim_q == RSP_CYC - 1'b1) begin
                            sh_q    <= reg_rdata;
                            tim_q   <= '0;
                            bit_q   <= '0;
                            state_q <= D_TX;
                        end
                    end
                    D_TX: begin
                        tim_q <= owc_cnt_t'(tim_q + 1'b1);
                        if (tim_q == D_CYC - 1'b1) begin
                            tim_q <= '0;
                            sh_q  <= {1'b0, sh_q[BYTE_W-1:1]};
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'h7) begin
                                state_q <= D_CMD;
                            end
                        end
                    end
                    default: begin
                        state_q <= D_RECOV;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Line driver
    // ------------------------------------------------------------
    // Registered so the pin never glitches.
    always_ff @(posedge clk) begin
        if (rst) begin
            drv_n_q <= 1'b1;
        end else if (ce) begin
            drv_n_q <= !(!brk && state_q == D_TX &&
                         owc_drive_low(tim_q, sh_q[0], D_START_CYC,
                                       D_ZERO_CYC));
        end
    end

endmodule

/* rtl/owc_pkg.sv */
// Shared constants, types and helpers for the single-wire command link.
package owc_pkg;

    // ------------------------------------------------------------
    // Clock and field layout
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 40;
    localparam int BYTE_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int CMD_DIR_BIT  = 7;
    localparam int CNT_W        = 16;

    typedef logic [CNT_W-1:0] owc_cnt_t;

    // ------------------------------------------------------------
    // Link times in microseconds
    // ------------------------------------------------------------
    localparam int BREAK_TIME_US          = 190;
    localparam int BREAK_RECOVERY_TIME_US = 40;
    localparam int READ_RESPONSE_DELAY_US = 190;
    localparam int HOST_REPLY_TIMEOUT_US  = 400;
    localparam int HOST_START_LOW_TIME_US = 50;
    localparam int HOST_ZERO_LOW_TIME_US  = 100;
    localparam int HOST_BIT_CYCLE_TIME_US = 200;
    localparam int DEV_START_LOW_TIME_US  = 40;
    localparam int DEV_ZERO_LOW_TIME_US   = 100;
    localparam int DEV_BIT_CYCLE_TIME_US  = 200;

    // ------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------
    localparam owc_cnt_t BRK_CYC_DEF =
        owc_cnt_t'(BREAK_TIME_US * CLK_MHZ);
    localparam owc_cnt_t BRK_REC_CYC =
        owc_cnt_t'(BREAK_RECOVERY_TIME_US * CLK_MHZ);
    localparam owc_cnt_t RSP_CYC_DEF =
        owc_cnt_t'(READ_RESPONSE_DELAY_US * CLK_MHZ);
    localparam owc_cnt_t RSP_TO_CYC_DEF =
        owc_cnt_t'(HOST_REPLY_TIMEOUT_US * CLK_MHZ);
    localparam owc_cnt_t H_START_CYC =
        owc_cnt_t'(HOST_START_LOW_TIME_US * CLK_MHZ);
    localparam owc_cnt_t H_ZERO_CYC =
        owc_cnt_t'(HOST_ZERO_LOW_TIME_US * CLK_MHZ);
    localparam owc_cnt_t H_CYC_DEF =
        owc_cnt_t'(HOST_BIT_CYCLE_TIME_US * CLK_MHZ);
    localparam owc_cnt_t D_START_CYC =
        owc_cnt_t'(DEV_START_LOW_TIME_US * CLK_MHZ);
    localparam owc_cnt_t D_ZERO_CYC =
        owc_cnt_t'(DEV_ZERO_LOW_TIME_US * CLK_MHZ);
    localparam owc_cnt_t D_CYC_DEF =
        owc_cnt_t'(DEV_BIT_CYCLE_TIME_US * CLK_MHZ);
    // Receivers split one from zero halfway between the two lows.
    localparam owc_cnt_t H_THR_CYC =
        owc_cnt_t'((H_START_CYC + H_ZERO_CYC) / 2);
    localparam owc_cnt_t D_THR_CYC =
        owc_cnt_t'((D_START_CYC + D_ZERO_CYC) / 2);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic owc_drive_low(input owc_cnt_t t,
                                           input logic     b,
                                           input owc_cnt_t st,
                                           input owc_cnt_t zr);
        return (t < st) || (!b && (t < zr));
    endfunction

    function automatic logic owc_rx_bit(input owc_cnt_t low,
                                        input owc_cnt_t thr);
        return low < thr;
    endfunction

endpackage

/* rtl/owc_link_if.sv */
// Open-drain single-wire line shared by the host and the device end.
`timescale 1ns/1ps
interface owc_link_if;
    logic dev_out;
    logic dev_oe_n;
    logic host_out;
    logic host_oe_n;
    logic single_wire_line;

    // Only a low can be driven; the pull-up gives the high level.
    assign single_wire_line = !((!dev_oe_n && !dev_out) ||
                                (!host_oe_n && !host_out));

    modport dev (
        output dev_out,
        output dev_oe_n,
        input  single_wire_line
    );

    modport host (
        output host_out,
        output host_oe_n,
        input  single_wire_line
    );
endinterface

/* rtl/owc_host.sv */
// Host end: sends breaks, commands and data, and collects reply bytes.
`timescale 1ns/1ps
module owc_host #(
    parameter owc_pkg::owc_cnt_t BRK_CYC    = owc_pkg::BRK_CYC_DEF,
    parameter owc_pkg::owc_cnt_t H_CYC      = owc_pkg::H_CYC_DEF,
    parameter owc_pkg::owc_cnt_t RSP_TO_CYC = owc_pkg::RSP_TO_CYC_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    owc_link_if.host                        link,
    input  wire logic                       cmd_valid,
    output      logic                       cmd_ready,
    input  wire logic                       cmd_write,
    input  wire logic [owc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [owc_pkg::BYTE_W-1:0] cmd_wdata,
    output      logic                       wr_done,
    output      logic                       rsp_valid,
    output      logic [owc_pkg::BYTE_W-1:0] rsp_data,
    output      logic                       rsp_timeout
);
    import owc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_BRK  = 3'h1,
        H_BREC = 3'h3,
        H_TX   = 3'h2,
        H_RX   = 3'h6
    } owc_hst_t;

    owc_hst_t          state_q;
    owc_cnt_t          tim_q;
    owc_cnt_t          low_q;
    logic              line;
    logic              line_q;
    logic              rise;
    logic [15:0]       sh_q;
    logic [3:0]        bit_q;
    logic              wr_q;
    logic              need_brk_q;
    logic [BYTE_W-1:0] rsh_q;
    logic [2:0]        rbit_q;
    logic              drv_n_q;
    logic              done_q;
    logic              valid_q;
    logic              tout_q;

    assign line        = link.single_wire_line;
    assign rise        = line && !line_q;
    assign cmd_ready   = (state_q == H_IDLE);
    assign link.host_out  = 1'b0;
    assign link.host_oe_n = drv_n_q;
    assign wr_done     = done_q;
    assign rsp_valid   = valid_q;
    assign rsp_data    = rsh_q;
    assign rsp_timeout = tout_q;

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            line_q <= 1'b1;
            low_q  <= '0;
        end else if (ce) begin
            line_q <= line;
            low_q  <= line ? '0 : owc_cnt_t'(low_q + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= H_IDLE;
            tim_q      <= '0;
            sh_q       <= '0;
            bit_q      <= '0;
            wr_q       <= 1'b0;
            need_brk_q <= 1'b1;
            rsh_q      <= '0;
            rbit_q     <= '0;
            done_q     <= 1'b0;
            valid_q    <= 1'b0;
            tout_q     <= 1'b0;
        end else if (ce) begin
            done_q  <= 1'b0;
            valid_q <= 1'b0;
            tout_q  <= 1'b0;
            unique case (state_q)
                H_IDLE: begin
                    if (cmd_valid) begin
                        sh_q  <= {cmd_wdata, cmd_write, cmd_addr};
                        wr_q  <= cmd_write;
                        bit_q <= '0;
                        tim_q <= '0;
                        state_q <= need_brk_q ? H_BRK : H_TX;
                    end
                end
                H_BRK: begin
                    tim_q <= owc_cnt_t'(tim_q + 1'b1);
                    if (tim_q == BRK_CYC - 1'b1) begin
                        tim_q   <= '0;
                        state_q <= H_BREC;
                    end
                end
                H_BREC: begin
                    tim_q <= owc_cnt_t'(tim_q + 1'b1);
                    if (tim_q == BRK_REC_CYC - 1'b1) begin
                        tim_q      <= '0;
                        need_brk_q <= 1'b0;
                        state_q    <= H_TX;
                    end
                end
                H_TX: begin
                    tim_q <= owc_cnt_t'(tim_q + 1'b1);
                    if (tim_q == H_CYC - 1'b1) begin
                        tim_q <= '0;
                        sh_q  <= {1'b0, sh_q[15:1]};
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == (wr_q ? 4'hF : 4'h7)) begin
                            rbit_q  <= '0;
                            done_q  <= wr_q;
                            state_q <= wr_q ? H_IDLE : H_RX;
                        end
                    end
                end
                H_RX: begin
                    tim_q <= owc_cnt_t'(tim_q + 1'b1);
                    if (rise) begin
                        tim_q  <= '0;
                        rsh_q  <= {owc_rx_bit(low_q, D_THR_CYC),
                                   rsh_q[BYTE_W-1:1]};
                        rbit_q <= rbit_q + 1'b1;
                        if (rbit_q == 3'h7) begin
                            valid_q <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    end else if (line && tim_q == RSP_TO_CYC - 1'b1) begin
                        tout_q     <= 1'b1;
                        need_brk_q <= 1'b1;
                        state_q    <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line driver
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            drv_n_q <= 1'b1;
        end else if (ce) begin
            drv_n_q <= !((state_q == H_BRK) ||
                         (state_q == H_TX &&
                          owc_drive_low(tim_q, sh_q[0], H_START_CYC,
                                        H_ZERO_CYC)));
        end
    end

endmodule

/* tb/owc_link_properties.sv */
// Line-level checks between the host end and the device end.
`timescale 1ns/1ps
module owc_link_properties #(
    parameter int H_START = 2000,
    parameter int H_ZERO  = 4000,
    parameter int H_BRK   = 7600,
    parameter int H_CYC   = 8000,
    parameter int D_START = 1600,
    parameter int D_ZERO  = 4000,
    parameter int D_CYC   = 8000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dev_out,
    input wire logic dev_oe_n,
    input wire logic host_out,
    input wire logic host_oe_n,
    input wire logic single_wire_line
);
    logic [15:0] dlow_q;
    logic [15:0] hlow_q;
    logic [15:0] dgap_q;
    logic [15:0] hgap_q;

    // ----------
    // Counters
    // ----------
    always_ff @(posedge clk) begin
        if (rst || dev_oe_n) dlow_q <= 16'h0000;
        else dlow_q <= dlow_q + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (rst || host_oe_n) hlow_q <= 16'h0000;
        else hlow_q <= hlow_q + 16'h0001;
    end
    // Gap counters saturate, so a long idle never wraps to a short gap.
    always_ff @(posedge clk) begin
        if (rst) dgap_q <= 16'hFFFF;
        else if ($fell(dev_oe_n)) dgap_q <= 16'h0001;
        else if (dgap_q != 16'hFFFF) dgap_q <= dgap_q + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (rst) hgap_q <= 16'hFFFF;
        else if ($fell(host_oe_n)) hgap_q <= 16'h0001;
        else if (hgap_q != 16'hFFFF) hgap_q <= hgap_q + 16'h0001;
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_dev_out_low;
        !dev_out;
    endproperty
    a_dev_out_low: assert property (p_dev_out_low)
        else $error("device drives high");
    property p_release;
        $fell(rst) |-> dev_oe_n && host_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("driver held after reset");
    property p_no_collision;
        !(!dev_oe_n && !host_oe_n);
    endproperty
    a_no_collision: assert property (p_no_collision)
        else $error("line collision");
    property p_line_level;
        single_wire_line == (dev_oe_n && host_oe_n);
    endproperty
    a_line_level: assert property (p_line_level)
        else $error("line level wrong");
    property p_dev_low_len;
        $rose(dev_oe_n) |-> dlow_q == D_START || dlow_q == D_ZERO;
    endproperty
    a_dev_low_len: assert property (p_dev_low_len)
        else $error("device low length");
    property p_dev_low_max;
        !dev_oe_n |-> dlow_q < D_ZERO;
    endproperty
    a_dev_low_max: assert property (p_dev_low_max)
        else $error("device low too long");
    property p_host_low_len;
        $rose(host_oe_n) |-> hlow_q inside {H_START, H_ZERO, H_BRK};
    endproperty
    a_host_low_len: assert property (p_host_low_len)
        else $error("host low length");
    property p_dev_period;
        $fell(dev_oe_n) |-> dgap_q >= D_CYC;
    endproperty
    a_dev_period: assert property (p_dev_period)
        else $error("device cycle short");
    property p_host_period;
        $fell(host_oe_n) |-> hgap_q >= H_CYC;
    endproperty
    a_host_period: assert property (p_host_period)
        else $error("host cycle short");

    c_dev_one: cover property ($rose(dev_oe_n) && dlow_q == D_START);
    c_dev_zero: cover property ($rose(dev_oe_n) && dlow_q == D_ZERO);
    c_host_break: cover property ($rose(host_oe_n) && hlow_q == H_BRK);
endmodule

/* tb/one_wire_command_slave_test.sv */
// Self-checking bench for the host and device ends of the link.
`timescale 1ns/1ps
module one_wire_command_slave_test;
    import owc_pkg::*;

    // ----------
    // Setup
    // ----------
    localparam owc_cnt_t BRK  = 16'h1068;
    localparam owc_cnt_t HBRK = 16'h1130;
    localparam owc_cnt_t CYC  = 16'h1004;
    localparam owc_cnt_t RSP  = 16'h00C8;
    localparam owc_cnt_t RSPT = 16'h1194;

    logic        clk, rst, cmd_valid, cmd_ready, cmd_write, wr_done;
    logic        rsp_valid, rsp_timeout, reg_wr, reg_rd, break_seen;
    logic        reg_wr2, break_seen2;
    logic [6:0]  cmd_addr, reg_addr, reg_addr2;
    logic [7:0]  cmd_wdata, rsp_data, reg_wdata, reg_rdata, reg_wdata2;
    logic [7:0]  regs [128];
    logic [7:0]  shreg;
    logic [15:0] exp_q[$], wire_q[$];
    logic [31:0] seed_q;
    int          num_errors, comparisons, low_n, nbits;
    int          wr2_cnt, brk_cnt, brk2_cnt;

    owc_link_if owc_link_if_i ();
    owc_link_if owc_link_if_i2 ();
    assign owc_link_if_i2.host_out = 1'b0;

    owc_host #(.BRK_CYC(HBRK), .H_CYC(CYC), .RSP_TO_CYC(RSPT)) owc_host_i (
        .clk(clk), .rst(rst), .ce(1'b1), .link(owc_link_if_i.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .wr_done(wr_done),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_timeout(rsp_timeout));
    owc_dev #(.BRK_CYC(BRK), .RSP_CYC(RSP), .D_CYC(CYC)) owc_dev_i (
        .clk(clk), .rst(rst), .ce(1'b1), .link(owc_link_if_i.dev),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .break_seen(break_seen),
        .busy());
    owc_dev #(.BRK_CYC(BRK), .RSP_CYC(RSP), .D_CYC(CYC)) owc_dev_i2 (
        .clk(clk), .rst(rst), .ce(1'b1), .link(owc_link_if_i2.dev),
        .reg_addr(reg_addr2), .reg_wdata(reg_wdata2), .reg_wr(reg_wr2),
        .reg_rd(), .reg_rdata(8'h00), .break_seen(break_seen2), .busy());
    owc_link_properties #(.H_START(H_START_CYC), .H_ZERO(H_ZERO_CYC),
        .H_BRK(HBRK), .H_CYC(CYC), .D_START(D_START_CYC),
        .D_ZERO(D_ZERO_CYC), .D_CYC(CYC)) owc_link_properties_i (
        .clk(clk), .rst(rst), .dev_out(owc_link_if_i.dev_out),
        .dev_oe_n(owc_link_if_i.dev_oe_n),
        .host_out(owc_link_if_i.host_out),
        .host_oe_n(owc_link_if_i.host_oe_n),
        .single_wire_line(owc_link_if_i.single_wire_line));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------
    // Monitor
    // ----------
    always @(negedge clk) begin
        if (reg_wr === 1'b1) regs[reg_addr] <= reg_wdata;
        reg_rdata <= regs[reg_addr];
    end

    always @(posedge clk) begin
        #1;
        if (reg_wr === 1'b1)
            check("wr", {1'b1, reg_addr, reg_wdata}, exp_q.pop_front());
        if (reg_rd === 1'b1)
            check("rd", {1'b0, reg_addr, 8'h00}, exp_q.pop_front());
        if (rsp_valid === 1'b1)
            check("reply", {8'h00, rsp_data}, exp_q.pop_front());
        if (rsp_timeout === 1'b1)
            check("timeout", 16'h0001, 16'h0000);
        if (reg_wr2 === 1'b1) wr2_cnt++;
        if (break_seen === 1'b1) brk_cnt++;
        if (break_seen2 === 1'b1) brk2_cnt++;
        if (owc_link_if_i.single_wire_line === 1'b0) begin
            low_n++;
        end else begin
            if (low_n >= int'(BRK)) nbits = 0;
            else if (low_n > 0) begin
                shreg = {low_n < int'(H_THR_CYC), shreg[7:1]};
                nbits++;
                if (nbits == 8) begin
                    check("wire", {8'h00, shreg}, wire_q.pop_front());
                    nbits = 0;
                end
            end
            low_n = 0;
        end
    end

    task automatic request(input logic w, input logic [6:0] a,
                           input logic [7:0] d);
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask

    task automatic main_seq();
        logic [6:0] a;
        logic [7:0] d;
        int n;
        a = seed_q[6:0];
        d = seed_q[15:8];
        wire_q.push_back({9'h001, a});
        wire_q.push_back({8'h00, d});
        exp_q.push_back({1'b1, a, d});
        request(1'b1, a, d);
        for (n = 0; wr_done !== 1'b1 && n < 90000; n++) @(negedge clk);
        check("wr_done", 16'(n < 90000), 16'h0001);
        $display("write test done");
        wire_q.push_back({9'h000, a});
        wire_q.push_back({8'h00, d});
        exp_q.push_back({1'b0, a, 8'h00});
        exp_q.push_back({8'h00, d});
        request(1'b0, a, ~d);
        for (n = 0; reg_rd !== 1'b1 && n < 40000; n++) @(negedge clk);
        for (n = 0; owc_link_if_i.dev_oe_n !== 1'b0 && n < 1000; n++)
            @(negedge clk);
        check("delay", 16'(n >= RSP && n <= RSP + 3), 16'h0001);
        for (n = 0; rsp_valid !== 1'b1 && n < 40000; n++) @(negedge clk);
        check("host break", 16'(brk_cnt), 16'h0001);
        $display("read test done");
    endtask

    task automatic pulse2(input int lo, input int hi);
        owc_link_if_i2.host_oe_n = 1'b0;
        repeat (lo) @(negedge clk);
        owc_link_if_i2.host_oe_n = 1'b1;
        repeat (hi) @(negedge clk);
    endtask

    task automatic send_bit2(input logic b, input int gap);
        int lo;
        lo = b ? int'(H_START_CYC) : int'(H_ZERO_CYC);
        pulse2(lo, int'(CYC) - lo + gap);
    endtask

    // A command cut short by a break must leave no trace.
    task automatic side_seq();
        logic [15:0] w;
        w = {seed_q[31:24], 1'b1, seed_q[22:16]};
        pulse2(int'(HBRK), int'(BRK_REC_CYC));
        for (int i = 0; i < 3; i++) begin
            send_bit2(w[i], 0);
        end
        pulse2(int'(HBRK), int'(BRK_REC_CYC));
        check("breaks", 16'(brk2_cnt), 16'h0002);
        for (int i = 0; i < 16; i++) begin
            send_bit2(w[i], i == 3 ? 30000 : 0);
        end
        check("side wr", {reg_wdata2, 1'b1, reg_addr2}, w);
        check("side count", 16'(wr2_cnt), 16'h0001);
        $display("break test done");
    endtask

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        owc_link_if_i2.host_oe_n = 1'b1;
        seed_q = lfsr(32'h0805A8D6);
        repeat (10) @(negedge clk);
        rst = 1'b0;
        fork
            main_seq();
            side_seq();
        join
        repeat (10) @(negedge clk);
        finish_test();
    end

    initial begin
        repeat (200000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
